// >>> common/acr_pkg.sv
package acr_pkg;

	// ====================================================
	// register map, byte addresses on the AXI4-Lite bus
	localparam logic [7:0] ACR_OFF_INPUT_SEL = 8'h00;
	localparam logic [7:0] ACR_OFF_CTRL_A    = 8'h04;
	localparam logic [7:0] ACR_OFF_CTRL_B    = 8'h08;
	localparam logic [7:0] ACR_OFF_RES_LOW   = 8'h0C;
	localparam logic [7:0] ACR_OFF_RES_HIGH  = 8'h10;
	localparam int         ACR_ADDR_W        = 8;

	// ====================================================
	// reset values
	localparam logic [7:0] ACR_RST_INPUT_SEL = 8'h00;
	localparam logic [7:0] ACR_RST_CTRL_A    = 8'h00;
	localparam logic [7:0] ACR_RST_CTRL_B    = 8'h00;
	localparam logic [9:0] ACR_RST_RESULT    = 10'h000;

	// ====================================================
	// field positions
	localparam int ACR_REF_HI   = 7;
	localparam int ACR_REF_LO   = 6;
	localparam int ACR_LAR_BIT  = 5;
	localparam int ACR_CHAN_HI  = 3;
	localparam int ACR_EN_BIT   = 7;
	localparam int ACR_START_BIT = 6;
	localparam int ACR_ATE_BIT  = 5;
	localparam int ACR_FLAG_BIT = 4;
	localparam int ACR_IE_BIT   = 3;
	localparam int ACR_PS_HI    = 2;
	localparam int ACR_CME_BIT  = 6;
	localparam int ACR_TS_HI    = 2;

	// ====================================================
	// encodings
	localparam logic [1:0] ACR_REF_EXT_PIN  = 2'h0;
	localparam logic [1:0] ACR_REF_SUPPLY   = 2'h1;
	localparam logic [1:0] ACR_REF_RESERVED = 2'h2;
	localparam logic [1:0] ACR_REF_BANDGAP  = 2'h3;
	localparam logic [3:0] ACR_CHAN_LAST_IN = 4'h7;
	localparam logic [3:0] ACR_CHAN_BANDGAP = 4'hE;
	localparam logic [3:0] ACR_CHAN_GROUND  = 4'hF;
	localparam logic [2:0] ACR_TS_FREE_RUN  = 3'h0;

	// ====================================================
	// timing counts in converter clock cycles
	localparam logic [4:0] ACR_CONV_FIRST  = 5'd25;
	localparam logic [4:0] ACR_CONV_NORMAL = 5'd13;

	localparam logic [1:0] ACR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

	// control handed to the analog sampling core
	typedef struct packed {
		logic       powerOn;
		logic       busy;
		logic       initConv;
		logic [1:0] referenceSelect;
		logic [3:0] inputChannelSelect;
	} acr_core_ctrl_t;

endpackage

// >>> design/acr_control.sv
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Function
// - reference_select bits 7:6 pick external pin, supply, reserved or 1.1V bandgap
// - reference change during conversion applies only after that conversion completes
// - left_adjust_result bit 5 changes presented result immediately
// - input-select bit 4 always reads zero
// - channel codes 0-7 inputs, 8-13 reserved, 14 bandgap, 15 ground
// - channel change during conversion applies only after completion
// - converter_enable bit 7 powers converter; clearing aborts running conversion
// - conversion_start bit 6 starts conversion; free running needs only first
// - first conversion after enable takes 25 converter clocks, later ones 13
// - start bit reads one while busy; writing zero does nothing
// - auto trigger starts conversion on rising edge of selected trigger
// - done flag bit 4 set when a conversion completes, even while result updates are locked
// - done flag cleared by interrupt vector acknowledge or writing one
// - interrupt requested when flag, irq enable and global enable all set
// - prescaler codes give divide by 2,2,4,8,16,32,64,128
// - right justified: low byte bits 7:0, high byte bits 1:0
// - left justified: high byte bits 9:2, low byte bits 7:6 hold 1:0
// - reading low byte locks result updates until high byte read
// - control B bits 7,5:3 read zero; bits 2:0 trigger source field
// - trigger codes: free run, comparator, ext irq0, timers in order
// - result equals input times 1024 over reference, from the core
module acr_control (
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	input  wire logic                   clkEn,
	input  wire logic [7:0]             awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire logic [7:0]             araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	input  wire logic [9:0]             conversionResult,
	input  wire logic [7:1]             triggerFlags,
	input  wire logic                   globalIrqEnable,
	input  wire logic                   irqVectorAck,
	output logic                        irqRequest,
	output logic                        comparatorMuxEnable,
	output acr_pkg::acr_core_ctrl_t     coreCtrl
);
	import acr_pkg::*;

	// ====================================================
	// register state
	logic [1:0] refSel_reg;
	logic       leftAdjust_reg;
	logic [3:0] chanSel_reg;
	logic       enable_reg;
	logic       autoTrig_reg;
	logic       doneFlag_reg;
	logic       irqEn_reg;
	logic [2:0] divSel_reg;
	logic       cme_reg;
	logic [2:0] trigSel_reg;
	logic [9:0] result_reg;
	logic       resLock_reg;

	// ====================================================
	// converter state
	logic       busy_reg;
	logic       needInit_reg;
	logic       curInit_reg;
	logic [6:0] preCnt_reg;
	logic [4:0] convCnt_reg;
	logic       trigPrev_reg;
	logic [1:0] actRef_reg;
	logic [3:0] actChan_reg;

	// ====================================================
	// bus state
	logic                  awHeld_reg;
	logic                  wHeld_reg;
	logic [ACR_ADDR_W-1:0] awAddr_reg;
	logic [7:0]            wByte_reg;
	logic                  wLane_reg;

	logic       doWrite;
	logic       arTake;
	logic       wrInSel;
	logic       wrCtrlA;
	logic       wrCtrlB;
	logic [7:0] divisor;
	logic [6:0] divLast;
	logic       convTick;
	logic [4:0] convLen;
	logic       convDone;
	logic       trigNow;
	logic       trigEdge;
	logic       startReq;
	logic       abort;
	logic       flagSet;
	logic       flagClr;
	logic [7:0] resLow;
	logic [7:0] resHigh;
	logic [7:0] rdByte;
	logic       rdHit;

	// ====================================================
	// write decode
	assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
	assign wrInSel = doWrite && wLane_reg && (awAddr_reg == ACR_OFF_INPUT_SEL);
	assign wrCtrlA = doWrite && wLane_reg && (awAddr_reg == ACR_OFF_CTRL_A);
	assign wrCtrlB = doWrite && wLane_reg && (awAddr_reg == ACR_OFF_CTRL_B);
	assign arTake  = arvalid && arready;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			awready    <= 1'b1;
		end else if (clkEn) begin
			if (awvalid && awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= awaddr;
				awready    <= 1'b0;
			end else if (doWrite) begin
				awHeld_reg <= 1'b0;
			end
			if (bvalid && bready) begin
				awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wHeld_reg <= 1'b0;
			wByte_reg <= 8'h00;
			wLane_reg <= 1'b0;
			wready    <= 1'b1;
		end else if (clkEn) begin
			if (wvalid && wready) begin
				wHeld_reg <= 1'b1;
				wByte_reg <= wdata[7:0];
				wLane_reg <= wstrb[0];
				wready    <= 1'b0;
			end else if (doWrite) begin
				wHeld_reg <= 1'b0;
			end
			if (bvalid && bready) begin
				wready <= 1'b1;
			end
		end
	end

	// unmapped addresses still answer, with an error
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp  <= ACR_RESP_OKAY;
		end else if (clkEn) begin
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp  <= (awAddr_reg == ACR_OFF_INPUT_SEL || awAddr_reg == ACR_OFF_CTRL_A ||
					awAddr_reg == ACR_OFF_CTRL_B || awAddr_reg == ACR_OFF_RES_LOW ||
					awAddr_reg == ACR_OFF_RES_HIGH) ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ====================================================
	// software registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			refSel_reg     <= ACR_RST_INPUT_SEL[ACR_REF_HI:ACR_REF_LO];
			leftAdjust_reg <= ACR_RST_INPUT_SEL[ACR_LAR_BIT];
			chanSel_reg    <= ACR_RST_INPUT_SEL[ACR_CHAN_HI:0];
		end else if (clkEn && wrInSel) begin
			refSel_reg     <= wByte_reg[ACR_REF_HI:ACR_REF_LO];
			leftAdjust_reg <= wByte_reg[ACR_LAR_BIT];
			chanSel_reg    <= wByte_reg[ACR_CHAN_HI:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg   <= ACR_RST_CTRL_A[ACR_EN_BIT];
			autoTrig_reg <= ACR_RST_CTRL_A[ACR_ATE_BIT];
			irqEn_reg    <= ACR_RST_CTRL_A[ACR_IE_BIT];
			divSel_reg   <= ACR_RST_CTRL_A[ACR_PS_HI:0];
		end else if (clkEn && wrCtrlA) begin
			enable_reg   <= wByte_reg[ACR_EN_BIT];
			autoTrig_reg <= wByte_reg[ACR_ATE_BIT];
			irqEn_reg    <= wByte_reg[ACR_IE_BIT];
			divSel_reg   <= wByte_reg[ACR_PS_HI:0];
		end
	end

	// reserved bits of control B are simply not stored
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cme_reg     <= ACR_RST_CTRL_B[ACR_CME_BIT];
			trigSel_reg <= ACR_RST_CTRL_B[ACR_TS_HI:0];
		end else if (clkEn && wrCtrlB) begin
			cme_reg     <= wByte_reg[ACR_CME_BIT];
			trigSel_reg <= wByte_reg[ACR_TS_HI:0];
		end
	end

	// ====================================================
	// prescaler
	always_comb begin
		case (divSel_reg)
			3'h0: divisor = 8'd2;
			3'h1: divisor = 8'd2;
			3'h2: divisor = 8'd4;
			3'h3: divisor = 8'd8;
			3'h4: divisor = 8'd16;
			3'h5: divisor = 8'd32;
			3'h6: divisor = 8'd64;
			default: divisor = 8'd128;
		endcase
	end
	assign divLast  = 7'(divisor - 8'd1);
	assign convTick = enable_reg && (preCnt_reg >= divLast);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			preCnt_reg <= 7'h00;
		end else if (clkEn) begin
			if (!enable_reg || convTick) begin
				preCnt_reg <= 7'h00;
			end else begin
				preCnt_reg <= preCnt_reg + 7'd1;
			end
		end
	end

	// ====================================================
	// start sources
	assign abort   = wrCtrlA && !wByte_reg[ACR_EN_BIT];
	assign trigNow = (trigSel_reg == ACR_TS_FREE_RUN) ? 1'b0 : triggerFlags[trigSel_reg];
	assign trigEdge = autoTrig_reg && trigNow && !trigPrev_reg;
	// start together with enable counts as the initialising conversion
	assign startReq = !busy_reg && !abort &&
		((wrCtrlA && wByte_reg[ACR_START_BIT] && wByte_reg[ACR_EN_BIT]) ||
		(enable_reg && trigEdge));
	assign convLen  = curInit_reg ? ACR_CONV_FIRST : ACR_CONV_NORMAL;
	assign convDone = busy_reg && convTick && (convCnt_reg == 5'(convLen - 5'd1));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			trigPrev_reg <= 1'b0;
		end else if (clkEn) begin
			trigPrev_reg <= trigNow;
		end
	end

	// ====================================================
	// conversion sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg     <= 1'b0;
			convCnt_reg  <= 5'd0;
			curInit_reg  <= 1'b0;
			needInit_reg <= 1'b1;
		end else if (clkEn) begin
			if (abort) begin
				busy_reg     <= 1'b0;
				convCnt_reg  <= 5'd0;
				needInit_reg <= 1'b1;
			end else if (startReq) begin
				busy_reg     <= 1'b1;
				convCnt_reg  <= 5'd0;
				curInit_reg  <= needInit_reg || !enable_reg;
				needInit_reg <= 1'b0;
			end else if (convDone) begin
				convCnt_reg <= 5'd0;
				curInit_reg <= 1'b0;
				// free running restarts itself without a new start write
				busy_reg    <= autoTrig_reg && (trigSel_reg == ACR_TS_FREE_RUN);
			end else if (busy_reg && convTick) begin
				convCnt_reg <= convCnt_reg + 5'd1;
			end
		end
	end

	// sampled selections only follow software between conversions
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			actRef_reg  <= ACR_REF_EXT_PIN;
			actChan_reg <= 4'h0;
		end else if (clkEn && (!busy_reg || convDone)) begin
			actRef_reg  <= refSel_reg;
			actChan_reg <= chanSel_reg;
		end
	end

	// ====================================================
	// result and flag
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= ACR_RST_RESULT;
		end else if (clkEn && convDone && !resLock_reg) begin
			result_reg <= conversionResult;
		end
	end

	// result bytes are formatted on read so a justification change is immediate
	assign resLow  = leftAdjust_reg ? {result_reg[1:0], 6'h00} : result_reg[7:0];
	assign resHigh = leftAdjust_reg ? result_reg[9:2] : {6'h00, result_reg[9:8]};

	// flag still sets when locked so software sees it missed a sample
	assign flagSet = convDone;
	assign flagClr = irqVectorAck || (wrCtrlA && wByte_reg[ACR_FLAG_BIT]);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			doneFlag_reg <= ACR_RST_CTRL_A[ACR_FLAG_BIT];
		end else if (clkEn) begin
			if (flagSet) begin
				doneFlag_reg <= 1'b1;
			end else if (flagClr) begin
				doneFlag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irqRequest <= 1'b0;
		end else if (clkEn) begin
			irqRequest <= doneFlag_reg && irqEn_reg && globalIrqEnable;
		end
	end

	// ====================================================
	// read channel
	always_comb begin
		rdHit = 1'b1;
		case (araddr)
			ACR_OFF_INPUT_SEL: rdByte = {refSel_reg, leftAdjust_reg, 1'b0, chanSel_reg};
			ACR_OFF_CTRL_A: rdByte = {enable_reg, busy_reg, autoTrig_reg, doneFlag_reg,
				irqEn_reg, divSel_reg};
			ACR_OFF_CTRL_B: rdByte = {1'b0, cme_reg, 3'h0, trigSel_reg};
			ACR_OFF_RES_LOW: rdByte = resLow;
			ACR_OFF_RES_HIGH: rdByte = resHigh;
			default: begin
				rdByte = 8'h00;
				rdHit  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= ACR_RESP_OKAY;
		end else if (clkEn) begin
			if (arTake) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= {24'h00_0000, rdByte};
				rresp   <= rdHit ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			resLock_reg <= 1'b0;
		end else if (clkEn && arTake) begin
			if (araddr == ACR_OFF_RES_LOW) begin
				resLock_reg <= 1'b1;
			end else if (araddr == ACR_OFF_RES_HIGH) begin
				resLock_reg <= 1'b0;
			end
		end
	end

	// ====================================================
	// core side outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			coreCtrl            <= '0;
			comparatorMuxEnable <= 1'b0;
		end else if (clkEn) begin
			coreCtrl.powerOn            <= enable_reg;
			coreCtrl.busy               <= busy_reg;
			coreCtrl.initConv           <= busy_reg && curInit_reg;
			coreCtrl.referenceSelect    <= actRef_reg;
			coreCtrl.inputChannelSelect <= actChan_reg;
			comparatorMuxEnable         <= cme_reg;
		end
	end

endmodule

// >>> tb/acr_control_monitor.sv
`timescale 1ns/1ps
module acr_control_monitor (
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire logic                    awvalid,
	input wire logic                    awready,
	input wire logic                    wvalid,
	input wire logic                    wready,
	input wire logic [1:0]              bresp,
	input wire logic                    bvalid,
	input wire logic                    bready,
	input wire logic                    arvalid,
	input wire logic                    arready,
	input wire logic [31:0]             rdata,
	input wire logic                    rvalid,
	input wire logic                    rready,
	input wire logic                    globalIrqEnable,
	input wire logic                    irqRequest,
	input wire acr_pkg::acr_core_ctrl_t coreCtrl
);
	import acr_pkg::*;
	// ====================================================
	// one clock domain, so one default clocking
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// ====================================================
	// rules
	a_irq_global_gate: assert property (irqRequest |-> $past(globalIrqEnable))
		else $error("irq request without global enable");
	a_off_not_busy: assert property (!coreCtrl.powerOn |-> !coreCtrl.busy)
		else $error("busy while powered off");
	a_rdata_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
	a_init_at_start: assert property ($rose(coreCtrl.initConv) |-> $rose(coreCtrl.busy))
		else $error("initialising conversion began mid run");

	// ====================================================
	// bus handshakes
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer late");
	a_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_read_blocked: assert property (rvalid |-> !arready)
		else $error("second read taken");
	a_write_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("second write taken");
endmodule

bind acr_control acr_control_monitor u_mon (
	.clock,
	.rst_n,
	.awvalid,
	.awready,
	.wvalid,
	.wready,
	.bresp,
	.bvalid,
	.bready,
	.arvalid,
	.arready,
	.rdata,
	.rvalid,
	.rready,
	.globalIrqEnable,
	.irqRequest,
	.coreCtrl
);

// >>> tb/acr_control_tb.sv
`timescale 1ns/1ps
module tb;
	import acr_pkg::*;
	// ====================================================
	// signals
	logic            clock = 1'b0;
	logic            rst_n = 1'b0;
	logic [7:0]      awaddr = 8'h00;
	logic            awvalid = 1'b0;
	logic [31:0]     wdata = 32'h0;
	logic [3:0]      wstrb = 4'hF;
	logic            wvalid = 1'b0;
	logic            bready = 1'b0;
	logic [7:0]      araddr = 8'h00;
	logic            arvalid = 1'b0;
	logic            rready = 1'b0;
	logic [9:0]      convRes = 10'h2B5;
	logic [7:1]      trigFlags = 7'h00;
	logic            gie = 1'b0;
	logic            vecAck = 1'b0;
	logic            clkEn = 1'b1;
	logic            awready, wready, bvalid, arready, rvalid, irqRequest, cme;
	logic [1:0]      bresp, rresp, resp;
	logic [31:0]     rdata, rv;
	acr_core_ctrl_t  coreCtrl;
	int              failures = 0;
	int              n_compared = 0;
	int              busyCnt = 0;
	int              busyBase = 0;
	int              i;

	always #2.5 clock = ~clock;

	acr_control DUT (.clock, .rst_n, .clkEn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.conversionResult(convRes), .triggerFlags(trigFlags), .globalIrqEnable(gie),
		.irqVectorAck(vecAck), .irqRequest, .comparatorMuxEnable(cme), .coreCtrl);

	always @(posedge clock) begin
		if (coreCtrl.busy === 1'b1) busyCnt <= busyCnt + 1;
	end

	// ====================================================
	// tasks
	task automatic results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic hang();
		failures++;
		$display("Error bus wait ran out");
		results();
	endtask

	// starts one edge later so a strobe is never set twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clock);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (n >= 100) hang();
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clock);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rv = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 100) hang();
	endtask

	task automatic waitDone();
		int n;
		for (n = 0; n < 2000; n++) begin
			rd(ACR_OFF_CTRL_A);
			if (rv[6] === 1'b0) break;
		end
		if (n >= 2000) hang();
	endtask

	// tick phase is free, so up to one divisor early
	// flag written one at start, so a stale flag cannot pass the check
	task automatic conv(input logic [7:0] a, input int nt, input int dv);
		int len;
		busyBase = busyCnt;
		wr(ACR_OFF_CTRL_A, a | 8'h10);
		rd(ACR_OFF_CTRL_A);
		chk("start_busy", 32'(rv[6]), 32'h1);
		chk("flag_cleared", 32'(rv[4]), 32'h0);
		waitDone();
		len = busyCnt - busyBase;
		chk("conv_len", 32'(len >= (nt - 1) * dv + 1 && len <= nt * dv), 32'h1);
		chk("flag_set", 32'(rv[4]), 32'h1);
	endtask

	// ====================================================
	// sequence
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		for (i = 0; i < 5; i++) begin
			rd(8'(4 * i));
			chk("reset_val", rv, 32'h0);
		end
		wr(8'h14, 8'hFF);
		chk("unmapped_wr", 32'(resp), 32'(ACR_RESP_SLVERR));
		rd(8'h14);
		chk("unmapped_rd", 32'(resp), 32'(ACR_RESP_SLVERR));
		for (i = 0; i < 16; i++) begin
			wr(ACR_OFF_INPUT_SEL, {i[1:0], 2'b11, i[3:0]});
			rd(ACR_OFF_INPUT_SEL);
			chk("insel", rv, {24'h0, i[1:0], 2'b10, i[3:0]});
			chk("core_chan", 32'(coreCtrl.inputChannelSelect), 32'(i[3:0]));
			chk("core_ref", 32'(coreCtrl.referenceSelect), 32'(i[1:0]));
		end
		wstrb <= 4'h0;
		wr(ACR_OFF_INPUT_SEL, 8'h00);
		wstrb <= 4'hF;
		rd(ACR_OFF_INPUT_SEL);
		chk("strobe_off", rv, 32'hEF);
		wr(ACR_OFF_CTRL_B, 8'h47);
		rd(ACR_OFF_CTRL_B);
		chk("ctrl_b", rv, 32'h47);
		chk("cme", 32'(cme), 32'h1);
		wr(ACR_OFF_CTRL_B, 8'h00);
		wr(ACR_OFF_INPUT_SEL, 8'h47);
		conv(8'hC3, 25, 8);
		chk("ctrl_a", rv, 32'h93);
		rd(ACR_OFF_RES_LOW);
		chk("low_right", rv, 32'hB5);
		rd(ACR_OFF_RES_HIGH);
		chk("high_right", rv, 32'h02);
		wr(ACR_OFF_INPUT_SEL, 8'h67);
		rd(ACR_OFF_RES_LOW);
		chk("low_left", rv, 32'h40);
		rd(ACR_OFF_RES_HIGH);
		chk("high_left", rv, 32'hAD);
		wr(ACR_OFF_INPUT_SEL, 8'h47);
		// source change mid conversion waits for completion
		wr(ACR_OFF_CTRL_A, 8'hC3);
		// frozen longer than the conversion, so it must still be running after
		clkEn <= 1'b0;
		repeat (300) @(posedge clock);
		clkEn <= 1'b1;
		wr(ACR_OFF_INPUT_SEL, 8'hCE);
		chk("ref_held", 32'(coreCtrl.referenceSelect), 32'h1);
		chk("chan_held", 32'(coreCtrl.inputChannelSelect), 32'h7);
		rd(ACR_OFF_CTRL_A);
		chk("frozen_busy", 32'(rv[6]), 32'h1);
		waitDone();
		chk("ref_new", 32'(coreCtrl.referenceSelect), 32'h3);
		chk("chan_new", 32'(coreCtrl.inputChannelSelect), 32'hE);
		rd(ACR_OFF_RES_LOW);
		convRes <= 10'h1C3;
		conv(8'hC3, 13, 8);
		rd(ACR_OFF_RES_HIGH);
		chk("locked_high", rv, 32'h02);
		conv(8'hC3, 13, 8);
		rd(ACR_OFF_RES_LOW);
		chk("new_low", rv, 32'hC3);
		rd(ACR_OFF_RES_HIGH);
		chk("new_high", rv, 32'h01);
		for (i = 0; i < 8; i++) begin
			conv(8'hC0 | 8'(i), 13, (i < 2) ? 2 : (1 << i));
		end
		gie <= 1'b1;
		wr(ACR_OFF_CTRL_A, 8'h88);
		repeat (3) @(posedge clock);
		chk("irq_on", 32'(irqRequest), 32'h1);
		gie <= 1'b0;
		repeat (3) @(posedge clock);
		chk("irq_gated", 32'(irqRequest), 32'h0);
		gie <= 1'b1;
		wr(ACR_OFF_CTRL_A, 8'h98);
		rd(ACR_OFF_CTRL_A);
		chk("flag_w1c", rv, 32'h88);
		chk("irq_off", 32'(irqRequest), 32'h0);
		conv(8'hC8, 13, 2);
		chk("irq_again", 32'(irqRequest), 32'h1);
		vecAck <= 1'b1;
		@(posedge clock);
		vecAck <= 1'b0;
		repeat (3) @(posedge clock);
		chk("irq_vec", 32'(irqRequest), 32'h0);
		rd(ACR_OFF_CTRL_A);
		chk("flag_vec", rv, 32'h88);
		for (i = 1; i < 8; i++) begin
			wr(ACR_OFF_CTRL_B, 8'(i));
			wr(ACR_OFF_CTRL_A, 8'hA0);
			trigFlags <= ~7'(1 << (i - 1));
			repeat (4) @(posedge clock);
			rd(ACR_OFF_CTRL_A);
			chk("trig_other", 32'(rv[6]), 32'h0);
			trigFlags <= 7'h7F;
			repeat (2) @(posedge clock);
			rd(ACR_OFF_CTRL_A);
			chk("trig_sel", 32'(rv[6]), 32'h1);
			waitDone();
			trigFlags <= 7'h00;
		end
		wr(ACR_OFF_CTRL_B, 8'h00);
		busyBase = busyCnt;
		wr(ACR_OFF_CTRL_A, 8'hE0);
		repeat (200) @(posedge clock);
		chk("free_run", 32'(busyCnt - busyBase > 150), 32'h1);
		wr(ACR_OFF_CTRL_A, 8'h00);
		rd(ACR_OFF_CTRL_A);
		chk("abort", rv, 32'h10);
		chk("power_off", 32'(coreCtrl.powerOn), 32'h0);
		conv(8'hC0, 25, 2);
		results();
	end
endmodule
